/* include/fifo_1kx5_pkg.sv */
// package for the 1k x 5 clocked fifo control logic
// assumes a single system clock; both fifo clocks arrive as pins
package fifo_1kx5_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int DATA_W = 5;
   localparam int DEPTH = 1024;
   localparam int PTR_W = 10;
   localparam int CNT_W = PTR_W + 1;
   localparam int TOT_W = PTR_W + 2;
   localparam logic [TOT_W-1:0] DEPTH_TOT = 12'h400;
   localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
   // ----------------------------------------
   // staging buffer in the write path
   // ----------------------------------------
   localparam int BUF_DEPTH = 8;
   localparam int BUF_CNT_W = 4;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic RST_FULL_N = 1'b1;
   localparam logic RST_EMPTY_N = 1'b0;
   localparam logic RST_OE = 1'b0;
   localparam logic [DATA_W-1:0] RST_DATA = 5'h00;
   localparam int SYNC_W = 12;
   localparam logic [SYNC_W-1:0] RST_SYNC = 12'h000;

   // sampled pins of both ports
   typedef struct packed {
      logic write_clock;
      logic read_clock;
      logic write_enable_primary;
      logic write_enable_secondary;
      logic read_enable_primary;
      logic read_enable_secondary;
      logic gated_mode;
      logic [DATA_W-1:0] write_data;
   } pin_sample_t;
endpackage

/* verilog/fifo_1kx5.sv */
// control logic and storage of a 1024 x 5 clocked fifo
// assumes both port clocks and all port pins are asynchronous to sys_clk_in
// and are slower than it by enough for two-flop sampling and edge detection
// Functional notes
// - read on read edge when enables qualify
// - empty flag updated only at read edges
// - empty at read edge inhibits, outputs float
// - primary read enable low holds last word
// - gate low at read edge floats outputs
// - write on write edge when enables qualify
// - full flag updated at write edges, blocks
// - asynchronous active-low reset overrides everything
// - reset: not full, empty, outputs floating
// - 1024 x 5 array, wrapping pointers
// - ungated mode ignores full and empty

// ----------------------------------------
// staging buffer
// ----------------------------------------
module stage_buffer #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 8,
   parameter int CNT_W = 4
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out,
   output logic [CNT_W-1:0] count_out
);
   localparam int IDX_W = CNT_W - 1;
   logic [WIDTH-1:0] slot_ff [DEPTH];
   logic [CNT_W-1:0] wr_ptr_ff;
   logic [CNT_W-1:0] rd_ptr_ff;
   logic push;
   logic pop;

   assign count_out = wr_ptr_ff - rd_ptr_ff;
   assign in_ready_out = (count_out != CNT_W'(DEPTH));
   assign out_valid_out = (count_out != '0);
   assign out_data_out = slot_ff[rd_ptr_ff[IDX_W-1:0]];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_ptr_ff <= '0;
      end else if (push) begin
         wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_ptr_ff <= '0;
      end else if (pop) begin
         rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         slot_ff[wr_ptr_ff[IDX_W-1:0]] <= in_data_in;
      end
   end
endmodule

// ----------------------------------------
// fifo top
// ----------------------------------------
module fifo_1kx5 (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic write_clock_in,
   input wire logic read_clock_in,
   input wire logic write_enable_primary_in,
   input wire logic write_enable_secondary_in,
   input wire logic read_enable_primary_in,
   input wire logic read_enable_secondary_in,
   input wire logic gated_mode_in,
   input wire logic [fifo_1kx5_pkg::DATA_W-1:0] write_data_in,
   output logic [fifo_1kx5_pkg::DATA_W-1:0] read_data_out,
   output logic read_data_oe_out,
   output logic full_flag_n_out,
   output logic empty_flag_n_out,
   output logic write_dropped_out
);
   import fifo_1kx5_pkg::*;

   pin_sample_t sync1_ff;
   pin_sample_t sync2_ff;
   logic wclk_d_ff;
   logic rclk_d_ff;
   logic [DATA_W-1:0] mem_ff [DEPTH];
   logic [CNT_W-1:0] wr_ptr_ff;
   logic [CNT_W-1:0] rd_ptr_ff;
   logic full_n_ff;
   logic empty_n_ff;
   logic oe_ff;
   logic [DATA_W-1:0] q_ff;
   logic dropped_ff;
   logic w_edge;
   logic r_edge;
   logic w_gate;
   logic r_gate;
   logic w_take;
   logic r_take;
   logic buf_ready;
   logic buf_valid;
   logic [DATA_W-1:0] buf_data;
   logic [BUF_CNT_W-1:0] buf_count;
   logic drain;
   logic [CNT_W-1:0] arr_count;
   logic [CNT_W-1:0] nxt_rd_count;
   logic [TOT_W-1:0] nxt_total;

   // ----------------------------------------
   // pin sampling
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_ff <= RST_SYNC;
         sync2_ff <= RST_SYNC;
      end else begin
         sync1_ff <= {write_clock_in, read_clock_in, write_enable_primary_in,
                      write_enable_secondary_in, read_enable_primary_in,
                      read_enable_secondary_in, gated_mode_in, write_data_in};
         sync2_ff <= sync1_ff;
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wclk_d_ff <= 1'b0;
         rclk_d_ff <= 1'b0;
      end else begin
         wclk_d_ff <= sync2_ff.write_clock;
         rclk_d_ff <= sync2_ff.read_clock;
      end
   end

   assign w_edge = sync2_ff.write_clock & ~wclk_d_ff;
   assign r_edge = sync2_ff.read_clock & ~rclk_d_ff;

   // ----------------------------------------
   // port qualification
   // ----------------------------------------
   // gated mode uses latched flags, ungated the secondary enables
   assign w_gate = sync2_ff.gated_mode ? full_n_ff
                                       : sync2_ff.write_enable_secondary;
   assign r_gate = sync2_ff.gated_mode ? empty_n_ff
                                       : sync2_ff.read_enable_secondary;
   assign w_take = w_edge & sync2_ff.write_enable_primary & w_gate;
   assign r_take = r_edge & sync2_ff.read_enable_primary & r_gate;

   // ----------------------------------------
   // write staging
   // ----------------------------------------
   stage_buffer #(
      .WIDTH(DATA_W),
      .DEPTH(BUF_DEPTH),
      .CNT_W(BUF_CNT_W)
   ) u_stage (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .in_valid_in(w_take),
      .in_ready_out(buf_ready),
      .in_data_in(sync2_ff.write_data),
      .out_valid_out(buf_valid),
      .out_ready_in(drain),
      .out_data_out(buf_data),
      .count_out(buf_count)
   );

   // array accepts a staged word unless full in gated mode
   assign arr_count = wr_ptr_ff - rd_ptr_ff;
   assign drain = buf_valid & (~sync2_ff.gated_mode | (arr_count != CNT_W'(DEPTH)));

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         dropped_ff <= 1'b0;
      end else begin
         dropped_ff <= w_take & ~buf_ready;
      end
   end

   // ----------------------------------------
   // storage array and pointers
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (drain) begin
         mem_ff[wr_ptr_ff[PTR_W-1:0]] <= buf_data;
      end
   end

   // pointers wrap through the extra bit
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_ptr_ff <= CNT_ZERO;
      end else if (drain) begin
         wr_ptr_ff <= wr_ptr_ff + CNT_ONE;
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_ptr_ff <= CNT_ZERO;
      end else if (r_take) begin
         rd_ptr_ff <= rd_ptr_ff + CNT_ONE;
      end
   end

   // ----------------------------------------
   // flags
   // ----------------------------------------
   assign nxt_rd_count = arr_count - (r_take ? CNT_ONE : CNT_ZERO);
   assign nxt_total = TOT_W'(arr_count) + TOT_W'(buf_count) + TOT_W'(buf_ready & w_take);

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         empty_n_ff <= RST_EMPTY_N;
      end else if (r_edge) begin
         empty_n_ff <= (nxt_rd_count != CNT_ZERO);
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         full_n_ff <= RST_FULL_N;
      end else if (w_edge) begin
         full_n_ff <= (nxt_total < DEPTH_TOT);
      end
   end

   // ----------------------------------------
   // read data and output enable
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         oe_ff <= RST_OE;
      end else if (r_edge) begin
         oe_ff <= r_gate;
      end
   end

   // hold keeps q_ff; reset value gives zeros on first hold
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         q_ff <= RST_DATA;
      end else if (r_take) begin
         q_ff <= mem_ff[rd_ptr_ff[PTR_W-1:0]];
      end
   end

   assign read_data_out = q_ff;
   assign read_data_oe_out = oe_ff;
   assign full_flag_n_out = full_n_ff;
   assign empty_flag_n_out = empty_n_ff;
   assign write_dropped_out = dropped_ff;
endmodule

/* dv/fifo_1kx5_asserts.sv */
// port-level checker for the 1k x 5 fifo top
// assumes port pins change away from the rising edge of sys_clk_in
module fifo_1kx5_asserts (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic write_clock_in,
   input wire logic read_clock_in,
   input wire logic read_enable_secondary_in,
   input wire logic gated_mode_in,
   input wire logic [fifo_1kx5_pkg::DATA_W-1:0] read_data_out,
   input wire logic read_data_oe_out,
   input wire logic full_flag_n_out,
   input wire logic empty_flag_n_out,
   input wire logic write_dropped_out
);
   import fifo_1kx5_pkg::*;
   logic wc_ff, rc_ff;
   logic [5:0] wr_rise_ff, rd_rise_ff;
   // recent port clock rises, seen on the raw pins
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         {wc_ff, rc_ff, wr_rise_ff, rd_rise_ff} <= '0;
      end else begin
         wc_ff <= write_clock_in;
         rc_ff <= read_clock_in;
         wr_rise_ff <= {wr_rise_ff[4:0], write_clock_in & ~wc_ff};
         rd_rise_ff <= {rd_rise_ff[4:0], read_clock_in & ~rc_ff};
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence rd_recent; |rd_rise_ff; endsequence
   sequence wr_recent; |wr_rise_ff; endsequence
   rst_values_a: assert property (disable iff (1'b0) !nrst_in |->
      full_flag_n_out && !empty_flag_n_out && !read_data_oe_out) else $error("reset values");
   rst_release_a: assert property ($rose(nrst_in) |-> full_flag_n_out &&
      !empty_flag_n_out && !read_data_oe_out && !write_dropped_out) else $error("release");
   empty_latch_a: assert property ($changed(empty_flag_n_out) |-> rd_recent)
      else $error("empty flag moved");
   full_latch_a: assert property ($changed(full_flag_n_out) |-> wr_recent)
      else $error("full flag moved");
   q_hold_a: assert property ($changed({read_data_out, read_data_oe_out}) |->
      rd_recent) else $error("output moved");
   oe_gate_a: assert property (gated_mode_in && $rose(read_data_oe_out)
      |-> $past(empty_flag_n_out)) else $error("read while empty");
   oe_second_a: assert property (!gated_mode_in && $rose(read_data_oe_out)
      |-> $past(read_enable_secondary_in, 3)) else $error("read while gated off");
   inhibit_float_a: assert property (gated_mode_in && !empty_flag_n_out &&
      rd_rise_ff[0] |-> ##[1:4] !read_data_oe_out) else $error("no float");
endmodule
bind fifo_1kx5 fifo_1kx5_asserts chk (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
   .write_clock_in(write_clock_in), .read_clock_in(read_clock_in),
   .read_enable_secondary_in(read_enable_secondary_in), .gated_mode_in(gated_mode_in),
   .read_data_out(read_data_out), .read_data_oe_out(read_data_oe_out),
   .full_flag_n_out(full_flag_n_out), .empty_flag_n_out(empty_flag_n_out),
   .write_dropped_out(write_dropped_out));

/* dv/fifo_partner.sv */
// writer and reader model on the fifo port pins
// assumes calls come from one bench process, after reset
module fifo_partner (
   input wire logic sys_clk_in,
   output logic wclk_out,
   output logic rclk_out,
   output logic [3:0] en_out,
   output logic [fifo_1kx5_pkg::DATA_W-1:0] data_out
);
   import fifo_1kx5_pkg::*;
   // idle, enables low, until the bench has reset the fifo
   initial {wclk_out, rclk_out, en_out, data_out} = '0;
   task automatic edge_pulse(input logic wr);
      @(negedge sys_clk_in);
      if (wr) wclk_out = 1'b1;
      else rclk_out = 1'b1;
      repeat (4) @(negedge sys_clk_in);
      {wclk_out, rclk_out} = 2'b00;
      repeat (4) @(negedge sys_clk_in);
      en_out = 4'h0;
   endtask
   task automatic put(input logic [1:0] en, input logic [DATA_W-1:0] d);
      @(negedge sys_clk_in);
      {en_out, data_out} = {en, 2'b00, d};
      edge_pulse(1'b1);
      data_out = ~d;
   endtask
   task automatic take(input logic [1:0] en);
      @(negedge sys_clk_in);
      en_out = {2'b00, en};
      edge_pulse(1'b0);
   endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench for the 1k x 5 fifo top
// assumes the partner model drives both ports
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fifo_1kx5_pkg::*;
   typedef struct packed {
      logic g;
      logic rd;
      logic [1:0] en;
      logic [DATA_W-1:0] d;
      logic oe;
      logic [DATA_W-1:0] q;
      logic ef;
   } row_t;
   logic sys_clk_in = 1'b0;
   logic nrst_in = 1'b1;
   logic gated = 1'b1;
   logic wclk, rclk, oe, ff_n, ef_n;
   logic [3:0] en;
   logic [DATA_W-1:0] wd, q;
   logic dropped;
   int n_dropped = 0;
   int n_mismatch = 0;
   int checked = 0;
   // gated rows, then ungated rows
   row_t rows [16] = '{'{1,1,2,0,0,0,0}, '{1,0,2,10,0,0,0}, '{1,0,2,21,0,0,0},
      '{1,1,0,0,0,0,1}, '{1,1,0,0,1,0,1}, '{1,1,2,0,1,10,1}, '{1,1,0,0,1,10,1},
      '{1,1,2,0,1,21,0}, '{1,1,2,0,0,0,0}, '{1,0,0,31,0,0,0}, '{1,1,2,0,0,0,0},
      '{0,0,2,3,0,0,0}, '{0,0,3,7,0,0,0}, '{0,1,2,0,0,0,1}, '{0,1,3,0,1,7,0},
      '{0,1,1,0,1,7,0}};
   always #4 sys_clk_in = ~sys_clk_in;
   fifo_partner pm (.sys_clk_in(sys_clk_in), .wclk_out(wclk), .rclk_out(rclk), .en_out(en),
      .data_out(wd));
   fifo_1kx5 uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .write_clock_in(wclk),
      .read_clock_in(rclk), .write_enable_primary_in(en[3]),
      .write_enable_secondary_in(en[2]), .read_enable_primary_in(en[1]),
      .read_enable_secondary_in(en[0]), .gated_mode_in(gated), .write_data_in(wd),
      .read_data_out(q), .read_data_oe_out(oe), .full_flag_n_out(ff_n),
      .empty_flag_n_out(ef_n), .write_dropped_out(dropped));
   // lost staged writes, sampled away from the launching edge
   always @(negedge sys_clk_in) if (dropped !== 1'b0) n_dropped++;
   task automatic chk(input string nm, input logic [DATA_W-1:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic look(input logic o, input logic [DATA_W-1:0] d, input logic e);
      chk("oe", 5'(o), 5'(oe));
      if (o) chk("q", d, q);
      chk("empty", 5'(e), 5'(ef_n));
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk_in);
      n_mismatch++;
      $display("watchdog expired");
      tally_and_finish();
   end
   initial begin
      // asserted after every process waits, so the flops see the falling edge
      nrst_in <= 1'b0;
      repeat (20) @(negedge sys_clk_in);
      nrst_in = 1'b1;
      foreach (rows[i]) begin
         gated = rows[i].g;
         if (rows[i].rd) begin
            pm.take(rows[i].en);
            look(rows[i].oe, rows[i].q, rows[i].ef);
         end else begin
            pm.put(rows[i].en, rows[i].d);
            chk("full", 5'h01, 5'(ff_n));
         end
         $display("row %0d done", i);
      end
      gated = 1'b1;
      for (int i = 0; i < DEPTH; i++) pm.put(2'b10, 5'(i));
      chk("full", 5'h00, 5'(ff_n));
      pm.put(2'b10, 5'h1f);
      pm.take(2'b00);
      for (int i = 0; i < DEPTH; i++) begin
         pm.take(2'b10);
         chk("q", 5'(i), q);
      end
      look(1'b1, 5'h1f, 1'b0);
      chk("full", 5'h00, 5'(ff_n));
      pm.put(2'b00, 5'h00);
      chk("full", 5'h01, 5'(ff_n));
      pm.put(2'b10, 5'h11);
      pm.take(2'b00);
      pm.take(2'b00);
      look(1'b1, 5'h1f, 1'b1);
      $display("fill test done");
      nrst_in = 1'b0;
      #1;
      look(1'b0, 5'h00, 1'b0);
      chk("full", 5'h01, 5'(ff_n));
      @(negedge sys_clk_in) nrst_in = 1'b1;
      pm.put(2'b10, 5'h09);
      pm.take(2'b00);
      pm.take(2'b00);
      look(1'b1, 5'h00, 1'b1);
      $display("reset test done");
      chk("dropped", 5'h00, (n_dropped > 0) ? 5'h01 : 5'h00);
      tally_and_finish();
   end
endmodule
